// [src/scs_map.svh]
// register map, field positions, reset values and timing counts of the channel selector
//
// Contract
// [RQ1] One logical channel is reachable over wired RS-232, wired RS-485 and the optical port.
// [RQ2] One protocol setting governs every interface at once.
// [RQ3] RS-232 and RS-485 share a single baud rate setting.
// [RQ4] The optical port has its own baud rate setting, independent of the wired one.
// [RQ5] Both wired ports run together; the installation connects and uses only one of them.
// [RQ6] With a non-native link layer selected, native traffic is carried tunnelled inside it.
// [RQ7] Firmware loading is accepted only over the native service protocol.
// [RQ8] Applying the optical head wakes the channel from economy into transfer state.
// [RQ9] Optical transfer lasts until 180 s pass without traffic or the head is removed.
// [RQ10] During optical transfer the channel uses the optical port and wired traffic stops.
// [RQ11] An attached modem sends verbose result codes, has echo off and answers automatically.
// [RQ12] An attached modem keeps a fixed serial baud rate instead of auto-detecting it.
// [RQ13] An attached modem holds its data-set-ready line asserted, feeding the clear-to-send input.
// [RQ14] Modem network registration, signal strength and packet address are queried and shown.
// [RQ15] The optical idle timer restarts on every optical byte; expiry returns to economy (code: enters SCS_OPT_WAITOFF until the head is lifted).
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

`define SCS_OFF_CTRL      12'h000
`define SCS_OFF_WBAUD     12'h004
`define SCS_OFF_OBAUD     12'h008
`define SCS_OFF_STATUS    12'h00c
`define SCS_OFF_DIAG_CMD  12'h010
`define SCS_OFF_DIAG_REG  12'h014
`define SCS_OFF_DIAG_SIG  12'h018
`define SCS_OFF_DIAG_IP   12'h01c

// ctrl fields
`define SCS_CTRL_PROTO_LSB 0
`define SCS_CTRL_FWREQ_BIT 4
`define SCS_CTRL_RST       32'h0000_0000

// status fields
`define SCS_ST_ROUTE_BIT   0
`define SCS_ST_HEAD_BIT    1
`define SCS_ST_TUNNEL_BIT  2
`define SCS_ST_FWOK_BIT    3
`define SCS_ST_FWREJ_BIT   4
`define SCS_ST_CTS_BIT     5

`define SCS_WBAUD_RST      16'h0411
`define SCS_OBAUD_RST      16'h0823

`define SCS_CLK_HZ         32'h0131_2d00
`define SCS_IDLE_S         32'h0000_00b4

`endif

// [src/scs_pkg.sv]
// types shared by the channel selector files
package scs_pkg;
    typedef enum logic [3:0] {
        SCS_PROTO_NATIVE = 4'h0,
        SCS_PROTO_MODBUS = 4'h1
    } scs_proto_t;

    typedef enum logic [2:0] {
        SCS_OPT_ECO      = 3'b001,
        SCS_OPT_XFER     = 3'b010,
        SCS_OPT_WAITOFF  = 3'b100
    } scs_opt_state_t;
endpackage : scs_pkg

// [src/scs_top.sv]
// channel selector: wired and optical ports, shared protocol, optical wake and idle timeout
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_top #(
    parameter int unsigned IDLE_CYC = `SCS_IDLE_S * `SCS_CLK_HZ
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rs232_rxd,
    output logic             rs232_txd,
    input  wire logic        rs232_cts,
    input  wire logic        rs485_rxd,
    output logic             rs485_txd,
    output logic             rs485_de,
    input  wire logic        opt_rxd,
    output logic             opt_txd,
    input  wire logic        opt_head,
    input  wire logic        core_tx_vld,
    input  wire logic [7:0]  core_tx_data,
    output logic             core_tx_rdy,
    output logic             core_rx_vld,
    output logic [7:0]       core_rx_data,
    output logic [3:0]       core_proto,
    output logic             core_tunnel,
    output logic             core_opt_route,
    output logic             opt_awake
);
    // pin synchronisers: two flops each
    logic [4:0] s1_r;
    logic [4:0] s2_r;
    logic [4:0] pins;
    assign pins = {opt_head, rs232_cts, opt_rxd, rs485_rxd, rs232_rxd};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // lines idle high, head reads absent so reset gives no false wake
            s1_r <= 5'h0f;
            s2_r <= 5'h0f;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    logic head_s;
    logic cts_s;
    assign head_s = s2_r[4];
    assign cts_s  = s2_r[3];

    // registers
    logic [31:0] ctrl_r;
    logic [15:0] wbaud_r;
    logic [15:0] obaud_r;
    logic [7:0]  diag_reg_r;
    logic [7:0]  diag_sig_r;
    logic [31:0] diag_ip_r;
    logic        fw_ok_r;
    logic        fw_rej_r;
    logic        wr_en;
    logic        rd_en;
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && pready;

    scs_pkg::scs_proto_t proto;
    assign proto = scs_pkg::scs_proto_t'(ctrl_r[`SCS_CTRL_PROTO_LSB +: 4]);

    logic mapped;
    always_comb begin
        unique case (paddr)
            `SCS_OFF_CTRL, `SCS_OFF_WBAUD, `SCS_OFF_OBAUD, `SCS_OFF_STATUS,
            `SCS_OFF_DIAG_CMD, `SCS_OFF_DIAG_REG, `SCS_OFF_DIAG_SIG,
            `SCS_OFF_DIAG_IP: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r  <= `SCS_CTRL_RST;
            wbaud_r <= `SCS_WBAUD_RST;
            obaud_r <= `SCS_OBAUD_RST;
        end else if (wr_en) begin
            unique case (paddr)
                `SCS_OFF_CTRL:  ctrl_r  <= {27'h0, pwdata[4:0]};     // see [RQ2]
                `SCS_OFF_WBAUD: wbaud_r <= pwdata[15:0];             // see [RQ3]
                `SCS_OFF_OBAUD: obaud_r <= pwdata[15:0];             // see [RQ4]
                default: ;
            endcase
        end
    end

    // firmware load request honoured only on the native protocol
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fw_ok_r  <= 1'b0;
            fw_rej_r <= 1'b0;
        end else if (wr_en && paddr == `SCS_OFF_CTRL && pwdata[`SCS_CTRL_FWREQ_BIT]) begin
            fw_ok_r  <= (proto == scs_pkg::SCS_PROTO_NATIVE);    // see [RQ7]
            fw_rej_r <= (proto != scs_pkg::SCS_PROTO_NATIVE);    // see [RQ7]
        end
    end

    // modem diagnostics: firmware writes parsed registration, signal and address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_reg_r <= 8'h00;
            diag_sig_r <= 8'h00;
            diag_ip_r  <= 32'h0000_0000;
        end else if (wr_en) begin
            unique case (paddr)
                `SCS_OFF_DIAG_REG: diag_reg_r <= pwdata[7:0];        // see [RQ14]
                `SCS_OFF_DIAG_SIG: diag_sig_r <= pwdata[7:0];        // see [RQ14]
                `SCS_OFF_DIAG_IP:  diag_ip_r  <= pwdata;             // see [RQ14]
                default: ;
            endcase
        end
    end

    // optical state machine
    scs_pkg::scs_opt_state_t st_r;
    logic [31:0] idle_r;
    logic        opt_byte;
    logic        route_opt;
    assign route_opt = (st_r == scs_pkg::SCS_OPT_XFER);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r   <= scs_pkg::SCS_OPT_ECO;
            idle_r <= 32'h0;
        end else begin
            unique case (st_r)
                scs_pkg::SCS_OPT_ECO: begin
                    if (head_s) begin
                        st_r   <= scs_pkg::SCS_OPT_XFER;        // see [RQ8]
                        idle_r <= 32'h0;
                    end
                end
                scs_pkg::SCS_OPT_XFER: begin
                    if (!head_s) begin
                        st_r <= scs_pkg::SCS_OPT_ECO;           // see [RQ9]
                    end else if (idle_r >= IDLE_CYC - 1) begin
                        st_r <= scs_pkg::SCS_OPT_WAITOFF;       // see [RQ9] [RQ15]
                    end else if (opt_byte) begin
                        idle_r <= 32'h0;                         // see [RQ15]
                    end else begin
                        idle_r <= idle_r + 32'h1;
                    end
                end
                scs_pkg::SCS_OPT_WAITOFF: begin
                    // a head left in place after timeout must be lifted before the next wake
                    if (!head_s) begin
                        st_r <= scs_pkg::SCS_OPT_ECO;
                    end
                end
            endcase
        end
    end

    // ports: wired pair share one divider, optical has its own
    logic       w_rdy, o_rdy;
    logic       w232_v, w485_v, o_v;
    logic [7:0] w232_d, w485_d, o_d;
    logic       t232, t485, topt;
    logic       w485_rdy;
    logic       w_go, o_go;
    assign w_go = core_tx_vld && !route_opt;                 // see [RQ10]
    assign o_go = core_tx_vld && route_opt;                  // see [RQ10]

    scs_uart u_w232 (                                        // see [RQ1] [RQ3]
        .clk(clk), .rst_b(rst_b), .baud_div(wbaud_r), .rxd_s(s2_r[0]),
        .tx_vld(w_go), .tx_data(core_tx_data), .tx_rdy(w_rdy), .txd(t232),
        .rx_vld(w232_v), .rx_data(w232_d));
    scs_uart u_w485 (                                        // see [RQ1] [RQ3] [RQ5]
        .clk(clk), .rst_b(rst_b), .baud_div(wbaud_r), .rxd_s(s2_r[1]),
        .tx_vld(w_go), .tx_data(core_tx_data), .tx_rdy(w485_rdy), .txd(t485),
        .rx_vld(w485_v), .rx_data(w485_d));
    scs_uart u_opt (                                         // see [RQ1] [RQ4]
        .clk(clk), .rst_b(rst_b), .baud_div(obaud_r), .rxd_s(s2_r[2]),
        .tx_vld(o_go), .tx_data(core_tx_data), .tx_rdy(o_rdy), .txd(topt),
        .rx_vld(o_v), .rx_data(o_d));

    assign opt_byte = o_v || (o_go && o_rdy);

    // outputs registered; wired receive dropped while optical holds the channel
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rs232_txd      <= 1'b1;
            rs485_txd      <= 1'b1;
            rs485_de       <= 1'b0;
            opt_txd        <= 1'b1;
            core_rx_vld    <= 1'b0;
            core_rx_data   <= 8'h00;
            core_tx_rdy    <= 1'b0;
            core_proto     <= 4'h0;
            core_tunnel    <= 1'b0;
            core_opt_route <= 1'b0;
            opt_awake      <= 1'b0;
        end else begin
            rs232_txd      <= t232;
            rs485_txd      <= t485;
            rs485_de       <= !w485_rdy;
            opt_txd        <= topt;
            core_opt_route <= route_opt;
            opt_awake      <= route_opt;
            core_proto     <= proto;                         // see [RQ2]
            core_tunnel    <= (proto != scs_pkg::SCS_PROTO_NATIVE); // see [RQ6]
            core_tx_rdy    <= route_opt ? o_rdy : (w_rdy && w485_rdy);
            if (route_opt) begin
                core_rx_vld  <= o_v;                         // see [RQ10]
                core_rx_data <= o_d;
            end else begin
                core_rx_vld  <= w232_v || w485_v;            // see [RQ5]
                core_rx_data <= w232_v ? w232_d : w485_d;
            end
        end
    end

    // read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        unique case (paddr)
            `SCS_OFF_CTRL:     rd_val = ctrl_r;
            `SCS_OFF_WBAUD:    rd_val = {16'h0, wbaud_r};
            `SCS_OFF_OBAUD:    rd_val = {16'h0, obaud_r};
            `SCS_OFF_STATUS: begin
                rd_val[`SCS_ST_ROUTE_BIT]  = route_opt;
                rd_val[`SCS_ST_HEAD_BIT]   = head_s;
                rd_val[`SCS_ST_TUNNEL_BIT] = (proto != scs_pkg::SCS_PROTO_NATIVE);
                rd_val[`SCS_ST_FWOK_BIT]   = fw_ok_r;
                rd_val[`SCS_ST_FWREJ_BIT]  = fw_rej_r;
                rd_val[`SCS_ST_CTS_BIT]    = cts_s;          // see [RQ13]
            end
            `SCS_OFF_DIAG_REG: rd_val = {24'h0, diag_reg_r};
            `SCS_OFF_DIAG_SIG: rd_val = {24'h0, diag_sig_r};
            `SCS_OFF_DIAG_IP:  rd_val = diag_ip_r;
            default:           rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (psel && penable && !pready && !pwrite) begin
            prdata <= rd_val;
        end
    end
endmodule : scs_top

// [src/scs_uart.sv]
// one uart port: baud divider, byte transmit and receive
`timescale 1ns/1ps
module scs_uart (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] baud_div,
    input  wire logic        rxd_s,
    input  wire logic        tx_vld,
    input  wire logic [7:0]  tx_data,
    output logic             tx_rdy,
    output logic             txd,
    output logic             rx_vld,
    output logic [7:0]       rx_data
);
    logic [15:0] tcnt_r;
    logic [3:0]  tbit_r;
    logic [9:0]  tsh_r;
    logic [15:0] rcnt_r;
    logic [3:0]  rbit_r;
    logic [7:0]  rsh_r;

    assign tx_rdy = (tbit_r == 4'h0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tcnt_r <= 16'h0000;
            tbit_r <= 4'h0;
            tsh_r  <= 10'h3ff;
            txd    <= 1'b1;
        end else if (tbit_r == 4'h0) begin
            if (tx_vld) begin
                tsh_r  <= {1'b1, tx_data, 1'b0};
                // one extra step so the stop bit lasts a full bit time before ready
                tbit_r <= 4'hb;
                tcnt_r <= 16'h0000;
            end
        end else if (tcnt_r == 16'h0000) begin
            txd    <= tsh_r[0];
            tsh_r  <= {1'b1, tsh_r[9:1]};
            tbit_r <= tbit_r - 4'h1;
            tcnt_r <= baud_div;
        end else begin
            tcnt_r <= tcnt_r - 16'h0001;
        end
    end

    // samples mid-bit; start bit found on a low line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rcnt_r  <= 16'h0000;
            rbit_r  <= 4'h0;
            rsh_r   <= 8'h00;
            rx_vld  <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_vld <= 1'b0;
            if (rbit_r == 4'h0) begin
                if (!rxd_s) begin
                    rbit_r <= 4'ha;
                    rcnt_r <= {1'b0, baud_div[15:1]};
                end
            end else if (rcnt_r != 16'h0000) begin
                rcnt_r <= rcnt_r - 16'h0001;
            end else begin
                rcnt_r <= baud_div;
                rbit_r <= rbit_r - 4'h1;
                if (rbit_r == 4'ha) begin
                    if (rxd_s) begin
                        rbit_r <= 4'h0;
                    end
                end else if (rbit_r == 4'h1) begin
                    rx_vld  <= rxd_s;
                    rx_data <= rsh_r;
                end else begin
                    rsh_r <= {rxd_s, rsh_r[7:1]};
                end
            end
        end
    end
endmodule : scs_uart

// [tb/scs_host_model.sv]
// far-side serial model: frames bytes to the device and decodes its frames
`timescale 1ns/1ps
module scs_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] bit_cyc,
    input  wire logic        txd,
    output logic             rxd,
    output logic             cts
);
    logic [7:0] got[$];
    logic [7:0] sh;
    initial begin
        rxd = 1'b1;
        cts = 1'b1;
    end
    // fixed line speed, never echoes what it hears
    always begin
        @(negedge txd);
        repeat (bit_cyc + bit_cyc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            sh[i] = txd;
            repeat (bit_cyc) @(posedge clk);
        end
        got.push_back(sh);
    end
    task automatic send(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (bit_cyc) @(posedge clk);
        end
    endtask : send
endmodule : scs_host_model

// [tb/scs_top_asserts.sv]
// port-level assertions for the channel selector
`timescale 1ns/1ps
module scs_top_asserts #(
    parameter int unsigned IDLE_CYC = 200
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rs232_txd,
    input wire logic        rs485_txd,
    input wire logic        rs485_de,
    input wire logic        opt_txd,
    input wire logic        opt_rxd,
    input wire logic        opt_head,
    input wire logic [3:0]  core_proto,
    input wire logic        core_tunnel,
    input wire logic        core_opt_route,
    input wire logic        opt_awake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] idle_r;
    // cycles of optical transfer with both optical lines idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            idle_r <= 32'h0;
        else if (!core_opt_route || !opt_txd || !opt_rxd)
            idle_r <= 32'h0;
        else
            idle_r <= idle_r + 32'h1;
    end
    a_tunnel_proto: assert property (core_tunnel == (core_proto != 4'h0))
        else $error("tunnel flag disagrees with protocol");
    a_route_awake: assert property (core_opt_route == opt_awake)
        else $error("route and awake differ");
    a_wake_fast: assert property ($rose(opt_head) |-> ##[1:6] core_opt_route)
        else $error("no wake after head applied");
    a_head_gone: assert property (!opt_head [*8] |-> !core_opt_route)
        else $error("optical route without head");
    a_wired_quiet: assert property (core_opt_route |-> rs232_txd && rs485_txd)
        else $error("wired transmit during optical transfer");
    a_wired_pair: assert property (rs232_txd == rs485_txd)
        else $error("wired ports differ");
    a_de_busy: assert property (!rs485_txd |-> rs485_de)
        else $error("rs485 driver off while transmitting");
    a_opt_quiet: assert property (!core_opt_route |-> opt_txd)
        else $error("optical transmit outside transfer");
    // a received byte counts at its stop bit, so the line may be quiet up to a frame earlier
    a_idle_max: assert property (idle_r <= IDLE_CYC + 80)
        else $error("idle timeout missed");
    a_idle_min: assert property ($fell(core_opt_route) && opt_head |-> idle_r >= IDLE_CYC - 72)
        else $error("idle timeout too early");
    a_pready_one: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h01c))
        else $error("slave error does not match map");
endmodule : scs_top_asserts

bind scs_top scs_top_asserts #(.IDLE_CYC(IDLE_CYC)) u_chk (
    .clk, .rst_b, .paddr, .pready, .pslverr, .rs232_txd, .rs485_txd, .rs485_de, .opt_txd, .opt_rxd,
    .opt_head, .core_proto, .core_tunnel, .core_opt_route, .opt_awake
);

// [tb/tb.sv]
// self-checking bench for the channel selector
`timescale 1ns/1ps
`include "scs_map.svh"
module tb;
    logic        clk, rst_b, psel, penable, pwrite, core_tx_vld, opt_head;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, rs232_rxd, rs232_txd, rs232_cts, rs485_txd, rs485_de;
    logic        opt_rxd, opt_txd, core_tx_rdy, core_rx_vld, core_tunnel, core_opt_route;
    logic        opt_awake, rs485_rxd;
    logic [7:0]  core_tx_data, core_rx_data, b;
    logic [3:0]  core_proto;
    logic [32:0] rdq[$];
    logic [7:0]  rxq[$];
    int          num_errors, n_compared, seed;

    scs_top #(.IDLE_CYC(200)) uut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rs232_rxd, .rs232_txd, .rs232_cts, .rs485_rxd,
        .rs485_txd, .rs485_de, .opt_rxd, .opt_txd, .opt_head, .core_tx_vld, .core_tx_data,
        .core_tx_rdy, .core_rx_vld, .core_rx_data, .core_proto, .core_tunnel, .core_opt_route,
        .opt_awake);
    scs_host_model h232 (.clk, .bit_cyc(16'd10), .txd(rs232_txd), .rxd(rs232_rxd),
        .cts(rs232_cts));
    scs_host_model hopt (.clk, .bit_cyc(16'd6), .txd(opt_txd), .rxd(opt_rxd), .cts());
    scs_host_model h485 (.clk, .bit_cyc(16'd10), .txd(rs485_txd), .rxd(rs485_rxd), .cts());

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task check(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    always @(negedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0)
            check({pslverr, prdata}, rdq.pop_front());
        if (core_rx_vld === 1'b1 && rxq.size() == 0)
            check(1, 0);
        else if (core_rx_vld === 1'b1)
            check(core_rx_data, rxq.pop_front());
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // values read right after the edge are those the edge sampled
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            num_errors++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [11:0] a, input logic [32:0] e);
        rdq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task csend(input logic [7:0] v);
        int n;
        n = 0;
        while (core_tx_rdy !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        core_tx_vld <= 1'b1;
        core_tx_data <= v;
        @(posedge clk);
        core_tx_vld <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : csend

    task wroute(input logic v);
        int n;
        n = 0;
        while (core_opt_route !== v && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(core_opt_route, v);
    endtask : wroute

    initial begin
        #3000000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        seed = 32'h19c62b5b;
        {rst_b, psel, penable, pwrite, core_tx_vld, opt_head} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        core_tx_data = 8'h0;
        num_errors = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`SCS_OFF_CTRL, 33'h0);
        rd(`SCS_OFF_WBAUD, {17'h0, `SCS_WBAUD_RST});
        rd(`SCS_OFF_OBAUD, {17'h0, `SCS_OBAUD_RST});
        rd(`SCS_OFF_STATUS, 33'h20);
        rd(12'h020, 33'h1_0000_0000);
        apb(1'b1, 12'h020, 32'h5);
        apb(1'b1, `SCS_OFF_WBAUD, 32'h9);
        apb(1'b1, `SCS_OFF_OBAUD, 32'h5);
        rd(`SCS_OFF_WBAUD, 33'h9);
        rd(`SCS_OFF_OBAUD, 33'h5);
        b = 8'($random(seed));
        apb(1'b1, `SCS_OFF_DIAG_SIG, {24'h0, b});
        rd(`SCS_OFF_DIAG_SIG, {25'h0, b});
        apb(1'b1, `SCS_OFF_DIAG_IP, 32'hc0a8_0001);
        rd(`SCS_OFF_DIAG_IP, 33'h0_c0a8_0001);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            // protocol first, then the firmware request under that protocol
            apb(1'b1, `SCS_OFF_CTRL, 32'(p));
            apb(1'b1, `SCS_OFF_CTRL, 32'h10 | 32'(p));
            repeat (2) @(negedge clk);
            check(core_proto, 4'(p));
            check(core_tunnel, p != 0);
            apb(1'b0, `SCS_OFF_STATUS, 32'h0);
            check(q[3 + p], 1'b1);
            check(q[4 - p], 1'b0);
        end
        $display("test protocol done");
        for (int k = 0; k < 2; k++) begin
            b = 8'($random(seed));
            csend(b);
            repeat (140) @(negedge clk);
            check(h232.got.pop_front(), b);
            check(h485.got.pop_front(), b);
            b = 8'($random(seed));
            rxq.push_back(b);
            if (k == 0)
                h232.send(b);
            else
                h485.send(b);
            repeat (40) @(negedge clk);
            check(rxq.size(), 0);
        end
        $display("test wired done");
        @(posedge clk);
        opt_head <= 1'b1;
        wroute(1'b1);
        check(opt_awake, 1'b1);
        h232.send(8'h5a);
        b = 8'($random(seed));
        csend(b);
        repeat (90) @(negedge clk);
        check(hopt.got.pop_front(), b);
        check(h232.got.size(), 0);
        b = 8'($random(seed));
        rxq.push_back(b);
        hopt.send(b);
        repeat (150) @(negedge clk);
        check(rxq.size(), 0);
        check(core_opt_route, 1'b1);
        wroute(1'b0);
        repeat (20) @(negedge clk);
        check(core_opt_route, 1'b0);
        @(posedge clk);
        opt_head <= 1'b0;
        repeat (10) @(negedge clk);
        @(posedge clk);
        opt_head <= 1'b1;
        wroute(1'b1);
        @(posedge clk);
        opt_head <= 1'b0;
        wroute(1'b0);
        b = 8'($random(seed));
        csend(b);
        repeat (140) @(negedge clk);
        check(h232.got.pop_front(), b);
        check(hopt.got.size(), 0);
        $display("test optical done");
        report_and_stop();
    end
endmodule : tb
